// ### verilog/cssn_defines.svh
`ifndef CSSN_DEFINES_SVH
`define CSSN_DEFINES_SVH

// answer-to-reset characters
`define CSSN_TS        8'h3b
`define CSSN_T0        8'h97
`define CSSN_TA1       8'h95
`define CSSN_TD1_NEG   8'h80
`define CSSN_TD1_SPEC  8'h90
`define CSSN_TA2       8'h80
`define CSSN_TD2       8'h1f
`define CSSN_TA3       8'hc7
`define CSSN_CAT_IND   8'h80
`define CSSN_CSD_TAG   8'h31
`define CSSN_CSD_VAL   8'he0
`define CSSN_CAP_TAG   8'h73
`define CSSN_CAP_B1    8'hfe
`define CSSN_CAP_B2    8'h21
`define CSSN_CAP_B3    8'h00
// positions inside the full (specific mode) sequence
`define CSSN_ATR_TD1   4'h3
`define CSSN_ATR_TA2   4'h4
`define CSSN_ATR_LAST  4'he

// parameter selection
`define CSSN_PPSS      8'hff
`define CSSN_PPS0_ACK  8'h10
`define CSSN_PPS0_DEF  8'h00
`define CSSN_FI_372    4'h1
`define CSSN_FI_512    4'h9
`define CSSN_DI_1      4'h1
`define CSSN_DI_8      4'h4
`define CSSN_DI_16     4'h5

// commands and status words
`define CSSN_INS_STAT  8'hf2
`define CSSN_P2_TPL    8'h00
`define CSSN_HDR_LAST  3'h4
`define CSSN_TPL_TAG   8'h62
`define CSSN_TPL_LEN   8'h03
`define CSSN_TPL_DTAG  8'h82
`define CSSN_TPL_DLEN  8'h01
`define CSSN_TPL_DESC  8'h38
`define CSSN_STAT_LAST 4'h7
`define CSSN_SW_OK     16'h9000
`define CSSN_SW_SEC    16'h6982
`define CSSN_SW_P1P2   16'h6b00

`endif

// ### verilog/cssn_pkg.sv
package cssn_pkg;

  typedef struct packed {
    logic [3:0] fi;
    logic [3:0] di;
  } cssn_rate_t;

  typedef struct packed {
    logic [7:0] sw1;
    logic [7:0] sw2;
  } cssn_sw_t;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_ATR,
    ST_NEGO,
    ST_PPS_RX,
    ST_PPS_RSP,
    ST_CMD,
    ST_STAT_RSP
  } cssn_state_t;

endpackage : cssn_pkg

// ### verilog/cssn_card_start.sv
// Operation
// - send the answer-to-reset at the start of every card session
// - answer-to-reset carries global parameters introduced by protocol 15
// - historical bytes open with category indicator 80
// - card service data object first, card capabilities second
// - historical bytes use compact tag-length data objects
// - support rate pairs 512/8, 512/16 and 372/1
// - default rate after reset is 372/1, except warm reset into specific mode keeps the current rate
// - non-default parameters only after a selection exchange
// - every selection request gets a selection response
// - supported request is echoed; later characters use the new rate
// - status with P2=00 answered with control parameter template
// - both sides interpret answer-to-reset parameters by standard coding
// - cold reset enters negotiable mode and clears security state
// - warm reset enters negotiable or specific mode, clears security
// - answer after cold reset omits the specific mode byte
// - PIN-protected access after any reset rejected with 69 82
`timescale 1ns/1ps
`include "cssn_defines.svh"

module cssn_card_start
  import cssn_pkg::*;
#(
  parameter bit WARM_SPECIFIC = 1'b0
) (
  input  wire logic       mclk_i,
  input  wire logic       srst_i,
  input  wire logic       card_rst_n_i,
  input  wire logic       vcc_ok_i,
  input  wire logic [7:0] rx_data_i,
  input  wire logic       rx_valid_i,
  input  wire logic       tx_ready_i,
  input  wire logic       acc_req_i,
  input  wire logic       pin_ok_i,
  output logic [7:0]      tx_data_o,
  output logic            tx_valid_o,
  output cssn_rate_t      rate_o,
  output logic            mode_specific_o,
  output logic            session_open_o,
  output logic            sec_clear_o,
  output logic            pin_verified_o,
  output logic            acc_done_o,
  output cssn_sw_t        acc_sw_o
);

  localparam cssn_rate_t RATE_DEF = '{fi: `CSSN_FI_372, di: `CSSN_DI_1};

  function automatic logic [7:0] atr_byte(input logic [3:0] pos,
                                          input logic       spec);
    logic [7:0] b;
    b = 8'h00;
    unique case (pos)
      4'h0: b = `CSSN_TS;
      4'h1: b = `CSSN_T0;
      4'h2: b = `CSSN_TA1;
      4'h3: b = spec ? `CSSN_TD1_SPEC : `CSSN_TD1_NEG;
      4'h4: b = `CSSN_TA2;
      4'h5: b = `CSSN_TD2;
      4'h6: b = `CSSN_TA3;
      4'h7: b = `CSSN_CAT_IND;
      4'h8: b = `CSSN_CSD_TAG;
      4'h9: b = `CSSN_CSD_VAL;
      4'ha: b = `CSSN_CAP_TAG;
      4'hb: b = `CSSN_CAP_B1;
      4'hc: b = `CSSN_CAP_B2;
      4'hd: b = `CSSN_CAP_B3;
      default: b = 8'h00;
    endcase
    return b;
  endfunction : atr_byte

  function automatic logic rate_ok(input logic [7:0] p1);
    return p1 == {`CSSN_FI_372, `CSSN_DI_1} ||
           p1 == {`CSSN_FI_512, `CSSN_DI_8} ||
           p1 == {`CSSN_FI_512, `CSSN_DI_16};
  endfunction : rate_ok

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: a level counts once stages two and three agree

  logic [1:0]  pin_s1;
  logic [1:0]  pin_s2;
  logic [1:0]  pin_s3;
  logic [1:0]  pin_f;
  logic        up_q;
  logic        cold_pending;
  logic        spec;
  logic        up;
  logic        release_evt;
  logic        is_cold;

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      pin_s1 <= 2'h0;
      pin_s2 <= 2'h0;
      pin_s3 <= 2'h0;
      pin_f  <= 2'h0;
    end else begin
      pin_s1 <= {vcc_ok_i, card_rst_n_i};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_f  <= (pin_f & (pin_s2 ^ pin_s3)) | (pin_s3 & ~(pin_s2 ^ pin_s3));
    end
  end

  assign up          = pin_f[1] & pin_f[0];
  assign release_evt = up & ~up_q;
  assign is_cold     = cold_pending;

  // a reset release with power seen to fall since the last one is cold
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      up_q         <= 1'b0;
      cold_pending <= 1'b1;
      spec         <= 1'b0;
    end else begin
      up_q <= up;
      if (!pin_f[1]) begin
        cold_pending <= 1'b1;
      end else if (release_evt) begin
        cold_pending <= 1'b0;
      end
      if (release_evt) begin
        spec <= is_cold ? 1'b0 : WARM_SPECIFIC;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencing

  cssn_state_t state;
  logic [3:0]  idx;
  logic [7:0]  run_xor;
  logic        sent_last;
  logic [7:0]  pps0;
  logic [7:0]  pps1;
  logic [7:0]  pps_xor;
  logic [2:0]  pps_left;
  logic        pps_has1;
  logic [2:0]  hdr_cnt;
  logic [7:0]  hdr_ins;
  logic        p2_tpl;
  logic [7:0]  cur_byte;
  logic        cur_last;
  logic        pps_good;
  logic        tx_take;
  logic        seq_done;

  assign tx_take  = tx_valid_o & tx_ready_i;
  assign seq_done = tx_take & sent_last;
  assign pps_good = pps0[3:0] == 4'h0 && pps0[4] && pps_has1 &&
                    rate_ok(pps1) && pps_xor == 8'h00;

  always_comb begin
    cur_byte = 8'h00;
    cur_last = 1'b0;
    unique case (state)
      ST_ATR: begin
        // the specific mode byte is skipped unless warm specific
        if (idx == `CSSN_ATR_LAST || (!spec && idx == `CSSN_ATR_LAST - 4'h1))
        begin
          cur_byte = run_xor;                       // check character
          cur_last = 1'b1;
        end else if (!spec && idx >= `CSSN_ATR_TA2) begin
          cur_byte = atr_byte(idx + 4'h1, spec);
        end else begin
          cur_byte = atr_byte(idx, spec);
        end
      end
      ST_PPS_RSP: begin
        unique case (idx)
          4'h0: cur_byte = `CSSN_PPSS;
          4'h1: cur_byte = pps_good ? `CSSN_PPS0_ACK : `CSSN_PPS0_DEF;
          4'h2: cur_byte = pps_good ? pps1 : (`CSSN_PPSS ^ `CSSN_PPS0_DEF);
          default: cur_byte = `CSSN_PPSS ^ `CSSN_PPS0_ACK ^ pps1;
        endcase
        cur_last = pps_good ? idx == 4'h3 : idx == 4'h2;
      end
      ST_STAT_RSP: begin
        if (p2_tpl) begin
          unique case (idx)
            4'h0: cur_byte = `CSSN_INS_STAT;
            4'h1: cur_byte = `CSSN_TPL_TAG;
            4'h2: cur_byte = `CSSN_TPL_LEN;
            4'h3: cur_byte = `CSSN_TPL_DTAG;
            4'h4: cur_byte = `CSSN_TPL_DLEN;
            4'h5: cur_byte = `CSSN_TPL_DESC;
            4'h6: cur_byte = 8'(`CSSN_SW_OK >> 8);
            default: cur_byte = 8'(`CSSN_SW_OK);
          endcase
          cur_last = idx == `CSSN_STAT_LAST;
        end else begin
          cur_byte = (idx == 4'h0) ? 8'(`CSSN_SW_P1P2 >> 8) : 8'h00;
          cur_last = idx == 4'h1;
        end
      end
      ST_OFF, ST_NEGO, ST_PPS_RX, ST_CMD: begin
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      state <= ST_OFF;
    end else if (!up) begin
      state <= ST_OFF;
    end else if (release_evt) begin
      state <= ST_ATR;
    end else begin
      unique case (state)
        ST_OFF: state <= ST_OFF;
        ST_ATR: if (seq_done) state <= spec ? ST_CMD : ST_NEGO;
        ST_NEGO:
          if (rx_valid_i) begin
            state <= rx_data_i == `CSSN_PPSS ? ST_PPS_RX : ST_CMD;
          end
        ST_PPS_RX:
          if (rx_valid_i && hdr_cnt != 3'h0 && pps_left == 3'h1) begin
            state <= ST_PPS_RSP;
          end
        ST_PPS_RSP: if (seq_done) state <= ST_CMD;
        ST_CMD:
          if (rx_valid_i && hdr_cnt == `CSSN_HDR_LAST &&
              hdr_ins == `CSSN_INS_STAT) begin
            state <= ST_STAT_RSP;
          end
        ST_STAT_RSP: if (seq_done) state <= ST_CMD;
      endcase
    end
  end

  // byte handshake; valid drops for one cycle between bytes
  always_ff @(posedge mclk_i) begin
    if (srst_i || !up || release_evt) begin
      tx_valid_o <= 1'b0;
      tx_data_o  <= 8'h00;
      sent_last  <= 1'b0;
      idx        <= 4'h0;
      run_xor    <= 8'h00;
    end else if (tx_take) begin
      tx_valid_o <= 1'b0;
      idx        <= sent_last ? 4'h0 : idx + 4'h1;
      if (state == ST_ATR && idx != 4'h0) begin
        run_xor <= run_xor ^ tx_data_o;
      end
    end else if (!tx_valid_o &&
                 (state == ST_ATR || state == ST_PPS_RSP ||
                  state == ST_STAT_RSP)) begin
      tx_valid_o <= 1'b1;
      tx_data_o  <= cur_byte;
      sent_last  <= cur_last;
    end
  end

  // selection request and command header capture
  always_ff @(posedge mclk_i) begin
    if (srst_i || release_evt) begin
      pps0     <= 8'h00;
      pps1     <= 8'h00;
      pps_xor  <= 8'h00;
      pps_left <= 3'h0;
      pps_has1 <= 1'b0;
      hdr_cnt  <= 3'h0;
      hdr_ins  <= 8'h00;
      p2_tpl   <= 1'b0;
    end else if (rx_valid_i) begin
      unique case (state)
        ST_NEGO: begin
          pps_xor <= rx_data_i;
          hdr_cnt <= rx_data_i == `CSSN_PPSS ? 3'h0 : 3'h1;
        end
        ST_PPS_RX: begin
          pps_xor <= pps_xor ^ rx_data_i;
          if (hdr_cnt == 3'h0) begin
            pps0     <= rx_data_i;
            pps_has1 <= rx_data_i[4];
            pps_left <= 3'(rx_data_i[4]) + 3'(rx_data_i[5]) +
                        3'(rx_data_i[6]) + 3'h1;
            hdr_cnt  <= 3'h1;
          end else begin
            if (hdr_cnt == 3'h1 && pps_has1) pps1 <= rx_data_i;
            pps_left <= pps_left - 3'h1;
            hdr_cnt  <= 3'h2;
          end
        end
        ST_CMD: begin
          if (hdr_cnt == 3'h1) hdr_ins <= rx_data_i;
          if (hdr_cnt == 3'h3) p2_tpl <= rx_data_i == `CSSN_P2_TPL;
          hdr_cnt <= hdr_cnt == `CSSN_HDR_LAST ? 3'h0 : hdr_cnt + 3'h1;
        end
        ST_OFF, ST_ATR, ST_PPS_RSP, ST_STAT_RSP: begin
        end
      endcase
    end else if (state == ST_STAT_RSP || state == ST_PPS_RSP) begin
      // the selection count must not leak into the next command header
      hdr_cnt <= 3'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // rate, mode and security state

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      rate_o          <= RATE_DEF;
      mode_specific_o <= 1'b0;
      session_open_o  <= 1'b0;
    end else begin
      if (release_evt) begin
        mode_specific_o <= is_cold ? 1'b0 : WARM_SPECIFIC;
        if (is_cold || !WARM_SPECIFIC) begin
          rate_o <= RATE_DEF;
        end
      end else if (state == ST_PPS_RSP && seq_done && pps_good) begin
        rate_o <= pps1;
      end
      session_open_o <= state == ST_CMD || state == ST_STAT_RSP;
    end
  end

  // a verification that lands with a reset edge is lost on purpose
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      pin_verified_o <= 1'b0;
      sec_clear_o    <= 1'b0;
      acc_done_o     <= 1'b0;
      acc_sw_o       <= `CSSN_SW_OK;
    end else begin
      sec_clear_o <= release_evt;
      if (!up || release_evt) begin
        pin_verified_o <= 1'b0;
      end else if (pin_ok_i && session_open_o) begin
        pin_verified_o <= 1'b1;
      end
      acc_done_o <= acc_req_i && session_open_o;
      if (acc_req_i && session_open_o) begin
        acc_sw_o <= pin_verified_o ? `CSSN_SW_OK : `CSSN_SW_SEC;
      end
    end
  end

endmodule : cssn_card_start

// ### verification/cssn_card_start_monitor.sv
`timescale 1ns/1ps
module cssn_card_start_monitor
  import cssn_pkg::*;
(
  input wire logic       mclk_i,
  input wire logic       srst_i,
  input wire logic       tx_ready_i,
  input wire logic       acc_req_i,
  input wire logic [7:0] tx_data_o,
  input wire logic       tx_valid_o,
  input wire cssn_rate_t rate_o,
  input wire logic       mode_specific_o,
  input wire logic       session_open_o,
  input wire logic       sec_clear_o,
  input wire logic       pin_verified_o,
  input wire logic       acc_done_o,
  input wire cssn_sw_t   acc_sw_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  a_tx_hold:
    assert property (tx_valid_o && !tx_ready_i |=>
      tx_valid_o && $stable(tx_data_o)) else $error("tx byte dropped");
  a_tx_drop:
    assert property (tx_valid_o && tx_ready_i |=> !tx_valid_o)
      else $error("tx valid kept after take");
  a_rate_legal:
    assert property (rate_o inside {8'h11, 8'h94, 8'h95})
      else $error("unsupported rate");
  a_rate_dflt:
    assert property (sec_clear_o && !mode_specific_o |-> rate_o == 8'h11)
      else $error("rate not default at reset");
  a_sec_clear:
    assert property (sec_clear_o |-> !pin_verified_o && !session_open_o)
      else $error("security kept over reset");
  a_acc_ans:
    assert property (acc_req_i && session_open_o |=> acc_done_o)
      else $error("access not answered");
  a_acc_closed:
    assert property (acc_req_i && !session_open_o |=> !acc_done_o)
      else $error("access answered while closed");
  a_acc_sw:
    assert property (acc_done_o |-> acc_sw_o ==
      ($past(pin_verified_o) ? 16'h9000 : 16'h6982))
      else $error("wrong access status");
endmodule : cssn_card_start_monitor
bind cssn_card_start cssn_card_start_monitor mon (.mclk_i, .srst_i,
  .tx_ready_i, .acc_req_i, .tx_data_o, .tx_valid_o, .rate_o,
  .mode_specific_o, .session_open_o, .sec_clear_o, .pin_verified_o,
  .acc_done_o, .acc_sw_o);

// ### verification/cssn_term_model.sv
`timescale 1ns/1ps
module cssn_term_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] txd_i,
  input  wire logic       txv_i,
  output logic            rst_n_o,
  output logic            vcc_o,
  output logic [7:0]      rxd_o,
  output logic            rxv_o,
  output logic            rdy_o
);
  logic [7:0] got[$];
  logic [1:0] cnt;
  logic       slow;
  initial begin
    rst_n_o = 0; vcc_o = 0; rxd_o = 8'h00; rxv_o = 0;
    rdy_o = 1; cnt = 0; slow = 0;
  end
  // slow mode stalls the card's sender half the time
  always @(posedge clk_i) begin
    cnt <= cnt + 2'h1;
    rdy_o <= slow ? cnt[1] : 1'b1;
    if (txv_i && rdy_o) got.push_back(txd_i);
  end
  task send(input logic [7:0] b);
    @(posedge clk_i);
    rxd_o <= b;
    rxv_o <= 1;
    @(posedge clk_i);
    rxv_o <= 0;
    rxd_o <= ~b;
  endtask : send
  task rst(input logic cold);
    @(posedge clk_i);
    rst_n_o <= 0;
    vcc_o <= !cold;
    repeat (8) @(posedge clk_i);
    vcc_o <= 1;
    repeat (2) @(posedge clk_i);
    got.delete();
    rst_n_o <= 1;
  endtask : rst
endmodule : cssn_term_model

// ### verification/cssn_card_start_bench.sv
`timescale 1ns/1ps
module cssn_card_start_bench
  import cssn_pkg::*;
;
  logic mclk_i = 0, srst_i = 1, acc_req_i = 0, pin_ok_i = 0;
  logic rst_n, vcc, rxv, rdy, tx_valid_o, mode_specific_o;
  logic session_open_o, sec_clear_o, pin_verified_o, acc_done_o;
  logic [7:0] rxd, tx_data_o;
  cssn_rate_t rate_o;
  cssn_sw_t   acc_sw_o;
  int fails = 0, compares = 0, cyc = 0;
  always #12.5 mclk_i = ~mclk_i;
  cssn_term_model term (.clk_i(mclk_i), .txd_i(tx_data_o),
    .txv_i(tx_valid_o), .rst_n_o(rst_n), .vcc_o(vcc), .rxd_o(rxd),
    .rxv_o(rxv), .rdy_o(rdy));
  cssn_card_start uut (.mclk_i(mclk_i), .srst_i(srst_i),
    .card_rst_n_i(rst_n), .vcc_ok_i(vcc), .rx_data_i(rxd),
    .rx_valid_i(rxv), .tx_ready_i(rdy), .acc_req_i(acc_req_i),
    .pin_ok_i(pin_ok_i), .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o),
    .rate_o(rate_o), .mode_specific_o(mode_specific_o),
    .session_open_o(session_open_o), .sec_clear_o(sec_clear_o),
    .pin_verified_o(pin_verified_o), .acc_done_o(acc_done_o),
    .acc_sw_o(acc_sw_o));
  ////////////////////////////////////////////////////////////////////////
  task give_verdict;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : give_verdict
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      fails++;
      give_verdict();
    end
  end
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task seq(input logic [7:0] e[$]);
    int k;
    k = 0;
    while (term.got.size() < e.size() && k < 600) begin
      @(posedge mclk_i);
      k++;
    end
    #1;
    chk("tx count", 16'(e.size()), 16'(term.got.size()));
    foreach (e[i]) if (i < term.got.size()) chk("tx_data_o", e[i], term.got[i]);
    term.got.delete();
  endtask : seq
  // cold or warm reset, then the answer-to-reset with its check byte
  task atr(input logic cold);
    logic [7:0] x;
    x = 8'h00;
    term.rst(cold);
    repeat (600) if (term.got.size() < 14) @(posedge mclk_i);
    foreach (term.got[i]) if (i > 0) x ^= term.got[i];
    chk("atr xor", 16'h0, 16'(x));
    term.got.pop_back();
    seq('{8'h3b, 8'h97, 8'h95, 8'h80, 8'h1f, 8'hc7, 8'h80, 8'h31, 8'he0,
          8'h73, 8'hfe, 8'h21, 8'h00});
    chk("rate_o", 16'h11, 16'(rate_o));
    chk("mode_specific_o", 16'h0, 16'(mode_specific_o));
  endtask : atr
  task status(input logic [7:0] p2);
    term.send(8'h80); term.send(8'hf2); term.send(8'h00);
    term.send(p2); term.send(8'h00);
    if (p2 == 8'h00) seq('{8'hf2, 8'h62, 8'h03, 8'h82, 8'h01, 8'h38,
                           8'h90, 8'h00});
    else seq('{8'h6b, 8'h00});
  endtask : status
  task pps(input logic [7:0] p1, input logic ok);
    atr(1);
    term.send(8'hff); term.send(8'h10); term.send(p1);
    term.send(8'hef ^ p1);
    if (ok) seq('{8'hff, 8'h10, p1, 8'hef ^ p1});
    else seq('{8'hff, 8'h00, 8'hff});
    chk("rate_o", ok ? 16'(p1) : 16'h11, 16'(rate_o));
    status(ok ? 8'h00 : 8'h01);
    $display("test pps %h done", p1);
  endtask : pps
  task acc(input logic pin, input logic [15:0] e);
    @(posedge mclk_i);
    pin_ok_i <= pin;
    @(posedge mclk_i);
    pin_ok_i <= 0;
    acc_req_i <= 1;
    @(posedge mclk_i);
    acc_req_i <= 0;
    #1;
    chk("acc_done_o", 16'h1, 16'(acc_done_o));
    chk("acc_sw_o", e, 16'(acc_sw_o));
  endtask : acc
  task t_security;
    atr(1); status(8'h00); acc(1, 16'h9000);
    atr(0); status(8'h00); acc(0, 16'h6982);
    acc(1, 16'h9000);
    atr(1); status(8'h00); acc(0, 16'h6982);
    $display("test security done");
  endtask : t_security
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge mclk_i);
    srst_i <= 0;
    acc_req_i <= 1;
    @(posedge mclk_i);
    acc_req_i <= 0;
    #1;
    chk("acc_done_o closed", 16'h0, 16'(acc_done_o));
    pps(8'h94, 1);
    pps(8'h95, 1);
    pps(8'h11, 1);
    term.slow = 1;
    pps(8'h96, 0);
    term.slow = 0;
    atr(1); status(8'h00);
    t_security();
    give_verdict();
  end
endmodule : cssn_card_start_bench
